//--- vc_regs_defines.svh
// Offsets, field positions and reset values of the virtual channel block
`ifndef VC_REGS_DEFINES_SVH
`define VC_REGS_DEFINES_SVH
// ****************************************************
// Address map, byte offsets inside the block
// ****************************************************
`define BLK_AW 14
`define OFS_VCH 14'h0000
`define OFS_VC_CAPABILITY_WORD1 14'h0004
`define OFS_VC_CAPABILITY_WORD2 14'h0008
`define OFS_PVC 14'h000C
`define OFS_PVS 14'h000E
`define OFS_VC0_RESOURCE_CAPABILITY 14'h0010
`define OFS_VC0_RESOURCE_CONTROL 14'h0014
`define OFS_VC0_RESOURCE_STATE 14'h001A
`define OFS_VC1_RESOURCE_CAPABILITY 14'h001C
`define OFS_VC1_RESOURCE_CONTROL 14'h0020
`define OFS_VC1_RESOURCE_STATE 14'h0026
`define OFS_PAT 14'h0030
`define OFS_PAT_END 14'h006F
`define PAT_WORDS 16
`define OFS_PAT_WORD 12'h00C
// ****************************************************
// Reset and fixed values
// ****************************************************
`define RST_VCH 32'h10010002
`define RST_VC_CAPABILITY_WORD1 32'h00000801
`define RST_VC_CAPABILITY_WORD2 32'h00000001
`define RST_VC0_RESOURCE_CAPABILITY 32'h00000001
`define RST_V0TVM 7'h7F
`define RST_VC1_RESOURCE_CAPABILITY 32'h30008010
`define RST_HALF 16'h0000
// ****************************************************
// Field positions
// ****************************************************
`define EN_BIT 31
`define ID_LSB 24
`define MTS_LSB 16
`define PAS_LSB 17
`define LAT_BIT 16
`define TVM_LSB 1
`define NP_BIT 1
`define ATS_BIT 0
`define PAS_TIMED_WRR 3'h4
`endif

//--- vc_regs_pkg.sv
// Types shared by the virtual channel register block
package vc_regs_pkg;
    // Writable part of a VC resource control register
    typedef struct packed {
        logic en;
        logic [2:0] id;
        logic [2:0] portarb_select;
        logic [6:0] class_to_vc_map;
    } vc_ctl_type;
    // Table copy engine state
    typedef enum logic {
        TBL_IDLE = 1'b0,
        TBL_COPY = 1'b1
    } tbl_state_type;
endpackage

//--- port_arb_store.sv
// Port arbitration table: software image and live copy used by arbiter
`timescale 1ns/1ps
`default_nettype none
`include "vc_regs_defines.svh"
module port_arb_store (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic wr_en_i,
    input wire logic [3:0] wr_idx_i,
    input wire logic [31:0] wr_data_i,
    input wire logic [3:0] rd_idx_i,
    output logic [31:0] rd_data_o,
    input wire logic load_i,
    output logic busy_o,
    input wire logic [6:0] slot_i,
    output logic [3:0] port_o
);
    import vc_regs_pkg::*;
    logic [31:0] image_mem [`PAT_WORDS];
    logic [31:0] live_mem [`PAT_WORDS];
    tbl_state_type state_q, state_d;
    logic [3:0] idx_q, idx_d;
    logic [3:0] port_q;
    // ****************************************************
    // Copy sequencer
    // ****************************************************
    // One word per cycle; a load during a copy is ignored
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        unique case (state_q)
            TBL_IDLE: begin
                if (load_i) begin
                    state_d = TBL_COPY;
                    idx_d = 4'h0;
                end
            end
            TBL_COPY: begin
                idx_d = idx_q + 4'h1;
                if (idx_q == 4'hF) begin
                    state_d = TBL_IDLE;
                end
            end
        endcase
    end
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            state_q <= TBL_IDLE;
            idx_q <= 4'h0;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
        end
    end
    // Storage has no reset; software fills it before loading
    always_ff @(posedge core_clk_i) begin
        if (wr_en_i) begin
            image_mem[wr_idx_i] <= wr_data_i;
        end
        if (state_q == TBL_COPY) begin
            live_mem[idx_q] <= image_mem[idx_q];
        end
    end
    // Eight 4-bit entries per word, 128 phases in all
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            port_q <= 4'h0;
        end else begin
            port_q <= live_mem[slot_i[6:3]][{slot_i[2:0], 2'b00} +: 4];
        end
    end
    assign rd_data_o = image_mem[rd_idx_i];
    assign busy_o = (state_q == TBL_COPY);
    assign port_o = port_q;
endmodule
`default_nettype wire

//--- rc_virtual_channel_regs.sv
// Virtual channel capability register block of the root complex
//
// Overview of operation
// - Whole block decoded in memory space at the configured base.
// - Header: next pointer, version 1, VC capability identifier.
// - Capability word 1 reports 4-bit port arbitration entries.
// - Capability word 1 reports a 100 ns reference clock.
// - One extended VC (VC1), no low-priority extended VCs.
// - Capability word 2: fixed VC arbitration, no table offset.
// - VC arbitration select is read-only and steers nothing.
// - Load VC arbitration table bit always reads zero.
// - VC arbitration table status bit always reads zero.
// - VC0 reports fixed port arbitration, no table, unused slots.
// - VC0 accepts snoopable traffic and handles all transaction types.
// - VC0 enable reads one forever; software cannot clear it.
// - VC0 identifier is read-only and reports its channel ID.
// - VC0 port arbitration select is stored but steers nothing.
// - VC0 load port arbitration table bit is read-only.
// - VC0 class map is writable and resets mapping all classes.
`timescale 1ns/1ps
`default_nettype none
`include "vc_regs_defines.svh"
module rc_virtual_channel_regs (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [31:0] cfg_block_base_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [31:0] mem_wdata_i,
    output logic mem_ack_o,
    output logic [31:0] mem_rdata_o,
    input wire logic vc0_negotiating_i,
    input wire logic vc1_negotiating_i,
    input wire logic [6:0] arb_slot_i,
    output logic [6:0] vc0_class_map_o,
    output vc_regs_pkg::vc_ctl_type vc1_ctl_o,
    output logic [6:0] vc1_max_slots_o,
    output logic [3:0] arb_port_o
);
    import vc_regs_pkg::*;

    // ****************************************************
    // Decode
    // ****************************************************
    // True when the dword of addr holds the register at ofs
    function automatic logic word_is(input logic [31:0] addr,
                                     input logic [13:0] ofs);
        word_is = (addr[13:2] == ofs[13:2]);
    endfunction

    logic blk_hit;
    logic rd_go;
    logic wr_go;
    logic pat_sel;
    // Base is 16 KB aligned; only the upper address bits are compared
    assign blk_hit = mem_req_i &&
        (mem_addr_i[31:`BLK_AW] == cfg_block_base_i[31:`BLK_AW]);
    // Each request is one whole dword; no lane strobes exist
    assign rd_go = blk_hit && !mem_we_i;
    assign wr_go = blk_hit && mem_we_i;
    assign pat_sel = (mem_addr_i[13:0] >= `OFS_PAT) &&
        (mem_addr_i[13:0] <= `OFS_PAT_END);

    // ****************************************************
    // Writable state
    // ****************************************************
    logic [2:0] v0_pas_q, v0_pas_d;
    logic [6:0] v0_tvm_q, v0_tvm_d;
    vc_ctl_type v1_ctl_q, v1_ctl_d;
    logic [6:0] v1_mts_q, v1_mts_d;
    logic mts_locked_q, mts_locked_d;
    logic tbl_load;
    logic tbl_busy;
    logic [31:0] pat_rd;

    // Next values of the control fields on a register write
    always_comb begin
        v0_pas_d = v0_pas_q;
        v0_tvm_d = v0_tvm_q;
        v1_ctl_d = v1_ctl_q;
        v1_mts_d = v1_mts_q;
        mts_locked_d = mts_locked_q;
        tbl_load = 1'b0;
        if (wr_go && word_is(mem_addr_i, `OFS_VC0_RESOURCE_CONTROL)) begin
            // Select kept for readback only; VC0 arbitration is fixed
            v0_pas_d = mem_wdata_i[`PAS_LSB +: 3];
            v0_tvm_d = mem_wdata_i[`TVM_LSB +: 7];
        end
        if (wr_go && word_is(mem_addr_i, `OFS_VC1_RESOURCE_CAPABILITY) && !mts_locked_q) begin
            // Write-once: firmware sets the slot count a single time
            v1_mts_d = mem_wdata_i[`MTS_LSB +: 7];
            mts_locked_d = 1'b1;
        end
        if (wr_go && word_is(mem_addr_i, `OFS_VC1_RESOURCE_CONTROL)) begin
            v1_ctl_d.en = mem_wdata_i[`EN_BIT];
            v1_ctl_d.id = mem_wdata_i[`ID_LSB +: 3];
            v1_ctl_d.portarb_select = mem_wdata_i[`PAS_LSB +: 3];
            v1_ctl_d.class_to_vc_map = mem_wdata_i[`TVM_LSB +: 7];
            // Load uses the select value written in the same dword
            tbl_load = mem_wdata_i[`LAT_BIT] &&
                (mem_wdata_i[`PAS_LSB +: 3] == `PAS_TIMED_WRR);
        end
        // Port VC control holds no writable bit, writes fall away
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            v0_pas_q <= 3'h0;
            v0_tvm_q <= `RST_V0TVM;
            v1_ctl_q <= '0;
            // Only the slot field of the reset word is kept
            v1_mts_q <= 7'(`RST_VC1_RESOURCE_CAPABILITY >> `MTS_LSB);
            mts_locked_q <= 1'b0;
        end else begin
            v0_pas_q <= v0_pas_d;
            v0_tvm_q <= v0_tvm_d;
            v1_ctl_q <= v1_ctl_d;
            v1_mts_q <= v1_mts_d;
            mts_locked_q <= mts_locked_d;
        end
    end

    // ****************************************************
    // Port arbitration table
    // ****************************************************
    port_arb_store port_arb_store_inst (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .wr_en_i(wr_go && pat_sel),
        .wr_idx_i(4'(mem_addr_i[13:2] - `OFS_PAT_WORD)),
        .wr_data_i(mem_wdata_i),
        .rd_idx_i(4'(mem_addr_i[13:2] - `OFS_PAT_WORD)),
        .rd_data_o(pat_rd),
        .load_i(tbl_load),
        .busy_o(tbl_busy),
        .slot_i(arb_slot_i),
        .port_o(arb_port_o)
    );

    // ****************************************************
    // Read path
    // ****************************************************
    logic [31:0] rd_word;
    logic [15:0] v0_sts;
    logic [15:0] v1_sts;
    logic [31:0] v0_ctl_word;
    logic [31:0] v1_ctl_word;
    logic [31:0] v1_cap_word;

    // Assemble readable words; reserved positions stay zero
    always_comb begin
        v0_sts = `RST_HALF;
        v0_sts[`NP_BIT] = vc0_negotiating_i;
        // VC0 has no port table, so its status bit stays zero
        v1_sts = `RST_HALF;
        v1_sts[`NP_BIT] = vc1_negotiating_i;
        v1_sts[`ATS_BIT] = tbl_busy;
        v0_ctl_word = 32'h0000_0000;
        v0_ctl_word[`EN_BIT] = 1'b1;
        v0_ctl_word[`ID_LSB +: 3] = 3'h0;
        v0_ctl_word[`PAS_LSB +: 3] = v0_pas_q;
        v0_ctl_word[`LAT_BIT] = 1'b0;
        v0_ctl_word[`TVM_LSB +: 7] = v0_tvm_q;
        v0_ctl_word[0] = 1'b1; // Class 0 always rides on VC0
        v1_ctl_word = 32'h0000_0000;
        v1_ctl_word[`EN_BIT] = v1_ctl_q.en;
        v1_ctl_word[`ID_LSB +: 3] = v1_ctl_q.id;
        v1_ctl_word[`PAS_LSB +: 3] = v1_ctl_q.portarb_select;
        v1_ctl_word[`TVM_LSB +: 7] = v1_ctl_q.class_to_vc_map;
        v1_cap_word = `RST_VC1_RESOURCE_CAPABILITY;
        v1_cap_word[`MTS_LSB +: 7] = v1_mts_q;
        rd_word = 32'h0000_0000;
        if (pat_sel) begin
            rd_word = pat_rd;
        end else begin
            unique case (mem_addr_i[13:2])
                12'(`OFS_VCH >> 2): rd_word = `RST_VCH;
                // Entry size, tick period and channel counts
                12'(`OFS_VC_CAPABILITY_WORD1 >> 2): rd_word = `RST_VC_CAPABILITY_WORD1;
                12'(`OFS_VC_CAPABILITY_WORD2 >> 2): rd_word = `RST_VC_CAPABILITY_WORD2;
                // Select, load and table status all read zero
                12'(`OFS_PVC >> 2): rd_word = 32'h0000_0000;
                12'(`OFS_VC0_RESOURCE_CAPABILITY >> 2): rd_word = `RST_VC0_RESOURCE_CAPABILITY;
                12'(`OFS_VC0_RESOURCE_CONTROL >> 2): rd_word = v0_ctl_word;
                12'(`OFS_VC0_RESOURCE_STATE >> 2): rd_word = {v0_sts, `RST_HALF};
                12'(`OFS_VC1_RESOURCE_CAPABILITY >> 2): rd_word = v1_cap_word;
                12'(`OFS_VC1_RESOURCE_CONTROL >> 2): rd_word = v1_ctl_word;
                12'(`OFS_VC1_RESOURCE_STATE >> 2): rd_word = {v1_sts, `RST_HALF};
                default: rd_word = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************
    // Bus answer and outputs
    // ****************************************************
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [6:0] class_map_q;
    vc_ctl_type v1_out_q;
    logic [6:0] slots_q;

    // Answer one cycle after each hit; misses are left to others
    always_comb begin
        ack_d = blk_hit;
        rdata_d = rd_go ? rd_word : 32'h0000_0000;
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            class_map_q <= `RST_V0TVM;
            v1_out_q <= '0;
            // Slot output starts from the field of the reset word
            slots_q <= 7'(`RST_VC1_RESOURCE_CAPABILITY >> `MTS_LSB);
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            class_map_q <= v0_tvm_d;
            v1_out_q <= v1_ctl_d;
            slots_q <= v1_mts_d;
        end
    end

    assign mem_ack_o = ack_q;
    assign mem_rdata_o = rdata_q;
    assign vc0_class_map_o = class_map_q;
    assign vc1_ctl_o = v1_out_q;
    assign vc1_max_slots_o = slots_q;

    // ****************************************************
    // Checks
    // ****************************************************
    hit_answered_a: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        blk_hit |=> mem_ack_o)
        else $error("hit in block not answered");
    miss_silent_a: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        !blk_hit |=> !mem_ack_o && mem_rdata_o == 32'h0)
        else $error("answer without a hit");
    header_value_a: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        rd_go && word_is(mem_addr_i, `OFS_VCH)
        |=> mem_rdata_o == 32'h10010002)
        else $error("capability header wrong");
    cap_one_a: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        rd_go && word_is(mem_addr_i, `OFS_VC_CAPABILITY_WORD1)
        |=> mem_rdata_o[11:8] == 4'h8 && mem_rdata_o[6:0] == 7'h01)
        else $error("capability word 1 wrong");
    cap_two_a: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        rd_go && word_is(mem_addr_i, `OFS_VC_CAPABILITY_WORD2)
        |=> mem_rdata_o[31:24] == 8'h00 && mem_rdata_o[7:0] == 8'h01)
        else $error("capability word 2 wrong");
    port_ctl_zero_a: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        rd_go && word_is(mem_addr_i, `OFS_PVC) |=> mem_rdata_o == 32'h0)
        else $error("port VC control or status not zero");
    vc0_cap_a: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        rd_go && word_is(mem_addr_i, `OFS_VC0_RESOURCE_CAPABILITY)
        |=> mem_rdata_o[31:14] == 18'h0 && mem_rdata_o[7:0] == 8'h01)
        else $error("VC0 capability wrong");
    vc0_fixed_a: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        rd_go && word_is(mem_addr_i, `OFS_VC0_RESOURCE_CONTROL)
        |=> mem_rdata_o[31] && mem_rdata_o[26:24] == 3'h0 &&
            !mem_rdata_o[16])
        else $error("VC0 fixed fields wrong");
    class_map_a: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        wr_go && word_is(mem_addr_i, `OFS_VC0_RESOURCE_CONTROL)
        |=> vc0_class_map_o == $past(mem_wdata_i[7:1]) &&
            v0_pas_q == $past(mem_wdata_i[19:17]))
        else $error("VC0 map write lost");
    reserved_zero_a: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        rd_go && word_is(mem_addr_i, 14'h0028) |=> mem_rdata_o == 32'h0)
        else $error("reserved word not zero");
    // Busy must stand for the whole 16-word copy, then drop
    table_copy_a: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        tbl_load && !tbl_busy |=> tbl_busy [*8] ##1 tbl_busy [*8]
        ##1 !tbl_busy)
        else $error("table copy length wrong");
    // Read data must not leak onto the bus outside a read answer
    rdata_quiet_a: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        !mem_ack_o |-> mem_rdata_o == 32'h0)
        else $error("read data outside an answer");
    write_quiet_a: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        wr_go |=> mem_ack_o && mem_rdata_o == 32'h0)
        else $error("write answered with data");
    vc0_status_a: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        rd_go && word_is(mem_addr_i, `OFS_VC0_RESOURCE_STATE) |=> !mem_rdata_o[16])
        else $error("VC0 table status not zero");
endmodule
`default_nettype wire

//--- host_bus_model.sv
// Host software model issuing single dword memory cycles to the block
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input wire logic core_clk_i,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [31:0] mem_addr_o,
    output logic [31:0] mem_wdata_o
);
    // ****************************************************
    // Bus idle at time zero
    // ****************************************************
    initial begin
        mem_req_o = 1'b0;
        mem_we_o = 1'b0;
        mem_addr_o = 32'h00000000;
        mem_wdata_o = 32'h00000000;
    end

    // One dword per request, held for the single cycle it is taken in
    task automatic issue(input logic we, input logic [31:0] addr,
                         input logic [31:0] wdata);
        @(posedge core_clk_i);
        mem_req_o <= 1'b1;
        mem_we_o <= we;
        mem_addr_o <= {addr[31:2], 2'b00};
        mem_wdata_o <= wdata;
    endtask

    // Qualifiers are inverted on release so stale values never match
    task automatic release_bus();
        @(posedge core_clk_i);
        mem_req_o <= 1'b0;
        mem_we_o <= ~mem_we_o;
        mem_addr_o <= ~mem_addr_o;
        mem_wdata_o <= ~mem_wdata_o;
    endtask
endmodule
`default_nettype wire

//--- test_rc_virtual_channel_regs.sv
// Self-checking bench for the virtual channel register block
`timescale 1ns/1ps
`default_nettype none
module test_rc_virtual_channel_regs;
    import vc_regs_pkg::*;
    logic core_clk_i, resetn_i, mem_req, mem_we, mem_ack, vc0_neg, vc1_neg;
    logic [31:0] base, mem_addr, mem_wdata, mem_rdata, w;
    logic [6:0] arb_slot, class_map, max_slots;
    logic [3:0] arb_port;
    vc_ctl_type vc1_ctl;
    logic [31:0] exp_q[$];
    logic [31:0] port_arbitration_table [16];
    int n_errors, checks_done, seed;
    logic [13:0] ofs_t [9] = '{14'h0000, 14'h0004, 14'h0008, 14'h000C,
        14'h0010, 14'h0014, 14'h001C, 14'h0020, 14'h0028};
    logic [31:0] rst_t [9] = '{32'h10010002, 32'h00000801, 32'h00000001,
        32'h00000000, 32'h00000001, 32'h800000FF, 32'h30008010,
        32'h00000000, 32'h00000000};

    // ****************************************************
    // Clock, design and host model
    // ****************************************************
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    rc_virtual_channel_regs rc_virtual_channel_regs_inst (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .cfg_block_base_i(base),
        .mem_req_i(mem_req),
        .mem_we_i(mem_we),
        .mem_addr_i(mem_addr),
        .mem_wdata_i(mem_wdata),
        .mem_ack_o(mem_ack),
        .mem_rdata_o(mem_rdata),
        .vc0_negotiating_i(vc0_neg),
        .vc1_negotiating_i(vc1_neg),
        .arb_slot_i(arb_slot),
        .vc0_class_map_o(class_map),
        .vc1_ctl_o(vc1_ctl),
        .vc1_max_slots_o(max_slots),
        .arb_port_o(arb_port)
    );

    host_bus_model host_bus_model_inst (
        .core_clk_i(core_clk_i),
        .mem_req_o(mem_req),
        .mem_we_o(mem_we),
        .mem_addr_o(mem_addr),
        .mem_wdata_o(mem_wdata)
    );

    // ****************************************************
    // Checking and reporting
    // ****************************************************
    task automatic end_sim();
        if (n_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp_read(input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: read data exp %h got %h",
                     $time, exp, got);
        end
    endtask

    task automatic cmp_port(input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: output exp %h got %h",
                     $time, exp, got);
        end
    endtask

    // Every answer is matched against the oldest note; writes answer 0
    // Looked at mid-cycle, where the registered answer has settled
    always @(negedge core_clk_i) begin
        if (mem_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("wrong value at %0t: answer without request", $time);
            end else begin
                cmp_read(exp_q.pop_front(), mem_rdata);
            end
        end
    end

    // Hang guard: far above the longest sequence below
    initial begin
        repeat (3000) @(posedge core_clk_i);
        n_errors++;
        $display("wrong value at %0t: run did not finish", $time);
        end_sim();
    end

    // ****************************************************
    // Access helpers
    // ****************************************************
    task automatic acc(input logic we, input logic [13:0] ofs,
                       input logic [31:0] wdata, input logic [31:0] exp);
        exp_q.push_back(exp);
        host_bus_model_inst.issue(we, base | {18'h0, ofs}, wdata);
    endtask

    task automatic rd(input logic [13:0] ofs, input logic [31:0] exp);
        acc(1'b0, ofs, $random(seed), exp);
    endtask

    task automatic wr(input logic [13:0] ofs, input logic [31:0] data);
        acc(1'b1, ofs, data, 32'h00000000);
    endtask

    // Release the bus and let the answer edge land before looking
    task automatic settle();
        host_bus_model_inst.release_bus();
        arb_slot <= 7'($random(seed));
        @(negedge core_clk_i);
    endtask

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        seed = 32'hc3b6;
        n_errors = 0;
        checks_done = 0;
        resetn_i = 1'b0;
        vc0_neg = 1'b0;
        vc1_neg = 1'b0;
        arb_slot = 7'h00;
        base = $random(seed);
        base[13:0] = 14'h0000;
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        // Reset values, back to back, then writes to fixed places ignored
        for (int i = 0; i < 9; i++) rd(ofs_t[i], rst_t[i]);
        for (int i = 0; i < 9; i++) begin
            if (i < 5 || i == 8) wr(ofs_t[i], 32'hFFFFFFFF);
        end
        for (int i = 0; i < 9; i++) begin
            if (i < 5 || i == 8) rd(ofs_t[i], rst_t[i]);
        end
        settle();
        // Traffic class map and select stored, enable stays set
        for (int i = 0; i < 5; i++) begin
            w = (i == 0) ? 32'h00000000 : $random(seed);
            wr(14'h0014, w);
            settle();
            cmp_port({25'h0, w[7:1]}, {25'h0, class_map});
            rd(14'h0014, {1'b1, 11'h0, w[19:17], 9'h0, w[7:1], 1'b1});
            settle();
        end
        // Cycles outside the block are never answered
        host_bus_model_inst.issue(1'b1, base ^ 32'h00004014, 32'h0);
        host_bus_model_inst.issue(1'b0, base ^ 32'h80000000, 32'h0);
        settle();
        cmp_port({25'h0, w[7:1]}, {25'h0, class_map});
        // Negotiation levels show in the status halves
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk_i);
            vc0_neg <= i[0];
            vc1_neg <= i[1];
            rd(14'h0018, {14'h0, i[0], 17'h0});
            rd(14'h0024, {14'h0, i[1], 17'h0});
            settle();
        end
        // Slot count is write-once
        wr(14'h001C, 32'h002A0000);
        wr(14'h001C, 32'h00550000);
        rd(14'h001C, 32'h302A8010);
        settle();
        cmp_port(32'h0000002A, {25'h0, max_slots});
        // Table image, load, busy window and live lookup
        for (int k = 0; k < 16; k++) begin
            port_arbitration_table[k] = $random(seed);
            wr(14'h0030 + 14'(4 * k), port_arbitration_table[k]);
        end
        rd(14'h0034, port_arbitration_table[1]);
        wr(14'h0020, 32'h870900FE);
        rd(14'h0024, 32'h00030000);
        settle();
        cmp_port(32'h00003E7F, {18'h0, vc1_ctl});
        repeat (18) @(posedge core_clk_i);
        rd(14'h0024, 32'h00020000);
        rd(14'h0020, 32'h870800FE);
        settle();
        @(posedge core_clk_i);
        arb_slot <= 7'd21;
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        cmp_port({28'h0, port_arbitration_table[2][23:20]}, {28'h0, arb_port});
        repeat (3) @(posedge core_clk_i);
        if (exp_q.size() != 0) begin
            n_errors++;
            $display("wrong value at %0t: answers missing", $time);
        end
        end_sim();
    end
endmodule
`default_nettype wire
